// ---- core/dcr_pkg.sv ----
// shared constants, field positions and types of the dac configuration register bank
package dcr_pkg;

  // ==========================================================================
  // serial frame geometry
  localparam int ADDR_W      = 7;
  localparam int DATA_W      = 8;
  localparam int CNT_W       = 16;
  localparam int SYNC_STAGES = 2;
  localparam int RW_BIT      = 7;
  localparam logic [3:0] LAST_BIT_IDX = 4'h7;

  // ==========================================================================
  // register offsets
  localparam logic [ADDR_W-1:0] ADDR_SERIAL_PORT_CTRL = 7'h00;
  localparam logic [ADDR_W-1:0] ADDR_POWER_DOWN_CTRL  = 7'h01;
  localparam logic [ADDR_W-1:0] ADDR_INPUT_DATA_FMT   = 7'h03;
  localparam logic [ADDR_W-1:0] ADDR_I_ERR_CNT_LO     = 7'h70;
  localparam logic [ADDR_W-1:0] ADDR_I_ERR_CNT_HI     = 7'h71;
  localparam logic [ADDR_W-1:0] ADDR_Q_ERR_CNT_LO     = 7'h72;
  localparam logic [ADDR_W-1:0] ADDR_Q_ERR_CNT_HI     = 7'h73;
  localparam logic [ADDR_W-1:0] ADDR_SILICON_REV      = 7'h7f;

  // ==========================================================================
  // field positions
  localparam int SPC_SDIO_BIDIR_BIT = 7;
  localparam int SPC_LSB_FIRST_BIT  = 6;
  localparam int SPC_SOFT_RESET_BIT = 5;
  localparam int PD_I_DAC_BIT       = 7;
  localparam int PD_Q_DAC_BIT       = 6;
  localparam int PD_RX_BIT          = 5;
  localparam int PD_AUX_ADC_BIT     = 4;
  localparam int FMT_BINARY_BIT     = 7;
  localparam int FMT_Q_FIRST_BIT    = 6;
  localparam int REV_LSB            = 2;
  localparam int REV_W              = 4;

  // ==========================================================================
  // reset values and fill
  localparam logic SPC_SDIO_BIDIR_RST = 1'h0;
  localparam logic SPC_LSB_FIRST_RST  = 1'h0;
  localparam logic SPC_SOFT_RESET_RST = 1'h0;
  localparam logic PD_I_DAC_RST       = 1'h0;
  localparam logic PD_Q_DAC_RST       = 1'h0;
  localparam logic PD_RX_RST          = 1'h0;
  localparam logic PD_AUX_ADC_RST     = 1'h1;
  localparam logic FMT_BINARY_RST     = 1'h0;
  localparam logic FMT_Q_FIRST_RST    = 1'h0;
  localparam logic [DATA_W-1:0] READ_FILL = 8'h00;

  // ==========================================================================
  // types
  typedef struct packed {
    logic sdio_bidir;
    logic lsb_first;
    logic soft_reset;
    logic pd_i_dac;
    logic pd_q_dac;
    logic pd_rx;
    logic pd_aux_adc;
    logic fmt_binary;
    logic q_first;
  } dcr_cfg_t;

  typedef struct packed {
    logic csb_n;
    logic sclk;
    logic sdio;
  } dcr_pins_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_INSTR,
    ST_DATA_WR,
    ST_DATA_RD,
    ST_DONE
  } dcr_state_t;

endpackage : dcr_pkg

// ---- core/dcr_sync.sv ----
// multi-bit two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module dcr_sync #(
  parameter int         WIDTH   = 3,
  parameter int         STAGES  = dcr_pkg::SYNC_STAGES,
  parameter logic [2:0] RST_VAL = 3'h4
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             srst,
  // data
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  initial begin
    if (STAGES < 2 || WIDTH != 3) begin
      $error("dcr_sync: unsupported stages or width");
    end
  end

  // ==========================================================================
  // chain; only stage 1 reads stage 0
  logic [WIDTH-1:0] stage_ff [STAGES];

  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int k = 0; k < STAGES; k++) begin
        stage_ff[k] <= RST_VAL;
      end
    end else begin
      stage_ff[0] <= din;
      for (int k = 1; k < STAGES; k++) begin
        stage_ff[k] <= stage_ff[k-1];
      end
    end
  end

  assign dout = stage_ff[STAGES-1];

endmodule : dcr_sync

// ---- core/dcr_err_counter.sv ----
// saturating sample error counter
`timescale 1ns/1ps
module dcr_err_counter #(
  parameter int WIDTH = dcr_pkg::CNT_W
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             srst,
  // control
  input  wire logic             clr,
  input  wire logic             inc,
  // count
  output logic      [WIDTH-1:0] count_ff
);

  initial begin
    if (WIDTH < 1) begin
      $error("dcr_err_counter: width must be positive");
    end
  end

  // ==========================================================================
  // counter; saturates so a long error burst never wraps to a small value
  always_ff @(posedge mclk) begin
    if (srst || clr) begin
      count_ff <= '0;
    end else if (inc && count_ff != {WIDTH{1'b1}}) begin
      count_ff <= count_ff + WIDTH'(1);
    end
  end

endmodule : dcr_err_counter

// ---- core/dcr_bank.sv ----
// configuration register bank with four-wire serial slave and error counters
`timescale 1ns/1ps
// How it works
// - port control bit 7 makes data pin bidirectional
// - port control bit 6 selects lsb-first order
// - port control bit 5 holds device reset
// - power bits 7..5 power down i, q, receiver
// - power bit 4 aux converter, resets to one
// - format bit 7 selects straight binary samples
// - format bit 6 selects i/q pairing order
// - pairing zero means i first, else q
module dcr_bank #(
  parameter int         CNT_W    = dcr_pkg::CNT_W,
  parameter logic [3:0] REVISION = 4'h1
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             srst,
  // serial port pins
  input  wire logic             csb_n,
  input  wire logic             sclk,
  input  wire logic             sdio_i,
  output logic                  sdio_o_ff,
  output logic                  sdio_oe_ff,
  output logic                  sdo_ff,
  // sample error events from the data path
  input  wire logic             i_sample_err,
  input  wire logic             q_sample_err,
  // configuration to the device
  output dcr_pkg::dcr_cfg_t     cfg_ff,
  output logic                  dev_reset_ff,
  output logic      [CNT_W-1:0] i_err_count_ff,
  output logic      [CNT_W-1:0] q_err_count_ff
);

  initial begin
    if (CNT_W != 2 * dcr_pkg::DATA_W) begin
      $error("dcr_bank: error count must span exactly two byte registers");
    end
  end

  // ==========================================================================
  // helpers
  function automatic logic [7:0] order8(input logic [7:0] b, input logic lsb);
    logic [7:0] r;
    r = b;
    if (lsb) begin
      for (int k = 0; k < 8; k++) begin
        r[k] = b[7-k];
      end
    end
    return r;
  endfunction : order8

  // ==========================================================================
  // pin synchronisation
  dcr_pkg::dcr_pins_t pins_raw;
  dcr_pkg::dcr_pins_t pins_s;

  assign pins_raw = '{csb_n: csb_n, sclk: sclk, sdio: sdio_i};

  dcr_sync #(
    .WIDTH   (3),
    .STAGES  (dcr_pkg::SYNC_STAGES),
    .RST_VAL (3'h4)
  ) u_sync (
    .mclk (mclk),
    .srst (srst),
    .din  (pins_raw),
    .dout (pins_s)
  );

  logic sclk_d_ff;
  logic sclk_rise;
  logic sclk_fall;

  always_ff @(posedge mclk) begin
    if (srst) begin
      sclk_d_ff <= 1'b0;
    end else begin
      sclk_d_ff <= pins_s.sclk;
    end
  end

  assign sclk_rise = pins_s.sclk & ~sclk_d_ff;
  assign sclk_fall = ~pins_s.sclk & sclk_d_ff;

  // ==========================================================================
  // error counters
  logic [CNT_W-1:0] i_cnt;
  logic [CNT_W-1:0] q_cnt;

  dcr_err_counter #(
    .WIDTH (CNT_W)
  ) u_i_cnt (
    .mclk     (mclk),
    .srst     (srst),
    .clr      (cfg_ff.soft_reset),
    .inc      (i_sample_err),
    .count_ff (i_cnt)
  );

  dcr_err_counter #(
    .WIDTH (CNT_W)
  ) u_q_cnt (
    .mclk     (mclk),
    .srst     (srst),
    .clr      (cfg_ff.soft_reset),
    .inc      (q_sample_err),
    .count_ff (q_cnt)
  );

  // ==========================================================================
  // read decode; unmapped offsets and unused bits read as zero
  function automatic logic [7:0] rd_value(input logic [dcr_pkg::ADDR_W-1:0] a,
                                          input dcr_pkg::dcr_cfg_t c,
                                          input logic [CNT_W-1:0] ic,
                                          input logic [CNT_W-1:0] qc);
    logic [7:0] v;
    v = dcr_pkg::READ_FILL;
    case (a)
      dcr_pkg::ADDR_SERIAL_PORT_CTRL: begin
        v[dcr_pkg::SPC_SDIO_BIDIR_BIT] = c.sdio_bidir;
        v[dcr_pkg::SPC_LSB_FIRST_BIT]  = c.lsb_first;
        v[dcr_pkg::SPC_SOFT_RESET_BIT] = c.soft_reset;
      end
      dcr_pkg::ADDR_POWER_DOWN_CTRL: begin
        v[dcr_pkg::PD_I_DAC_BIT]   = c.pd_i_dac;
        v[dcr_pkg::PD_Q_DAC_BIT]   = c.pd_q_dac;
        v[dcr_pkg::PD_RX_BIT]      = c.pd_rx;
        v[dcr_pkg::PD_AUX_ADC_BIT] = c.pd_aux_adc;
      end
      dcr_pkg::ADDR_INPUT_DATA_FMT: begin
        v[dcr_pkg::FMT_BINARY_BIT]  = c.fmt_binary;
        v[dcr_pkg::FMT_Q_FIRST_BIT] = c.q_first;
      end
      dcr_pkg::ADDR_I_ERR_CNT_LO: v = ic[7:0];
      dcr_pkg::ADDR_I_ERR_CNT_HI: v = ic[15:8];
      dcr_pkg::ADDR_Q_ERR_CNT_LO: v = qc[7:0];
      dcr_pkg::ADDR_Q_ERR_CNT_HI: v = qc[15:8];
      dcr_pkg::ADDR_SILICON_REV: begin
        v[dcr_pkg::REV_LSB +: dcr_pkg::REV_W] = REVISION;
      end
      default: v = dcr_pkg::READ_FILL;
    endcase
    return v;
  endfunction : rd_value

  // ==========================================================================
  // serial frame sequencer
  dcr_pkg::dcr_state_t          state_ff;
  logic [3:0]                   bit_cnt_ff;
  logic [7:0]                   in_sr_ff;
  logic [7:0]                   out_sr_ff;
  logic [dcr_pkg::ADDR_W-1:0]   addr_ff;
  logic                         wr_stb_ff;
  logic [7:0]                   wr_data_ff;
  logic [7:0]                   shift_byte;
  logic [7:0]                   instr;

  assign shift_byte = {in_sr_ff[6:0], pins_s.sdio};
  assign instr      = order8(shift_byte, cfg_ff.lsb_first);

  always_ff @(posedge mclk) begin
    if (srst || pins_s.csb_n) begin
      state_ff   <= dcr_pkg::ST_IDLE;
      bit_cnt_ff <= '0;
    end else begin
      case (state_ff)
        dcr_pkg::ST_IDLE: begin
          state_ff   <= dcr_pkg::ST_INSTR;
          bit_cnt_ff <= '0;
        end
        dcr_pkg::ST_INSTR, dcr_pkg::ST_DATA_WR, dcr_pkg::ST_DATA_RD: begin
          if (sclk_rise) begin
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
            if (bit_cnt_ff == dcr_pkg::LAST_BIT_IDX) begin
              bit_cnt_ff <= '0;
              if (state_ff != dcr_pkg::ST_INSTR) begin
                state_ff <= dcr_pkg::ST_DONE;
              end else if (instr[dcr_pkg::RW_BIT]) begin
                state_ff <= dcr_pkg::ST_DATA_RD;
              end else begin
                state_ff <= dcr_pkg::ST_DATA_WR;
              end
            end
          end
        end
        dcr_pkg::ST_DONE: state_ff <= dcr_pkg::ST_DONE;
        default: state_ff <= dcr_pkg::ST_IDLE;
      endcase
    end
  end

  // input shifter, address capture and write strobe
  always_ff @(posedge mclk) begin
    if (srst) begin
      in_sr_ff   <= '0;
      addr_ff    <= '0;
      wr_stb_ff  <= 1'b0;
      wr_data_ff <= '0;
    end else begin
      wr_stb_ff <= 1'b0;
      if (sclk_rise && !pins_s.csb_n) begin
        in_sr_ff <= shift_byte;
        if (state_ff == dcr_pkg::ST_INSTR && bit_cnt_ff == dcr_pkg::LAST_BIT_IDX) begin
          addr_ff <= instr[dcr_pkg::ADDR_W-1:0];
        end
        if (state_ff == dcr_pkg::ST_DATA_WR && bit_cnt_ff == dcr_pkg::LAST_BIT_IDX) begin
          wr_stb_ff  <= 1'b1;
          wr_data_ff <= instr;
        end
      end
    end
  end

  // output shifter; loaded when the instruction completes, driven on falling sclk
  always_ff @(posedge mclk) begin
    if (srst) begin
      out_sr_ff <= '0;
    end else if (state_ff == dcr_pkg::ST_INSTR && sclk_rise
                 && bit_cnt_ff == dcr_pkg::LAST_BIT_IDX) begin
      out_sr_ff <= rd_value(instr[dcr_pkg::ADDR_W-1:0], cfg_ff, i_cnt, q_cnt);
    end else if (state_ff == dcr_pkg::ST_DATA_RD && sclk_fall) begin
      out_sr_ff <= cfg_ff.lsb_first ? {1'b0, out_sr_ff[7:1]}
                                    : {out_sr_ff[6:0], 1'b0};
    end
  end

  // read pins; the shared pin only drives in bidirectional mode
  always_ff @(posedge mclk) begin
    if (srst || pins_s.csb_n) begin
      sdo_ff     <= 1'b0;
      sdio_o_ff  <= 1'b0;
      sdio_oe_ff <= 1'b0;
    end else if (state_ff == dcr_pkg::ST_DATA_RD) begin
      if (sclk_fall) begin
        sdo_ff    <= cfg_ff.lsb_first ? out_sr_ff[0] : out_sr_ff[7];
        sdio_o_ff <= cfg_ff.lsb_first ? out_sr_ff[0] : out_sr_ff[7];
      end
      sdio_oe_ff <= cfg_ff.sdio_bidir;
    end else begin
      sdo_ff     <= 1'b0;
      sdio_o_ff  <= 1'b0;
      sdio_oe_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // serial port control register; never cleared by its own reset bit
  always_ff @(posedge mclk) begin
    if (srst) begin
      cfg_ff.sdio_bidir <= dcr_pkg::SPC_SDIO_BIDIR_RST;
      cfg_ff.lsb_first  <= dcr_pkg::SPC_LSB_FIRST_RST;
      cfg_ff.soft_reset <= dcr_pkg::SPC_SOFT_RESET_RST;
    end else if (wr_stb_ff && addr_ff == dcr_pkg::ADDR_SERIAL_PORT_CTRL) begin
      cfg_ff.sdio_bidir <= wr_data_ff[dcr_pkg::SPC_SDIO_BIDIR_BIT];
      cfg_ff.lsb_first  <= wr_data_ff[dcr_pkg::SPC_LSB_FIRST_BIT];
      cfg_ff.soft_reset <= wr_data_ff[dcr_pkg::SPC_SOFT_RESET_BIT];
    end
  end

  // held in reset as long as the bit stays set
  always_ff @(posedge mclk) begin
    if (srst) begin
      dev_reset_ff <= 1'b0;
    end else begin
      dev_reset_ff <= cfg_ff.soft_reset;
    end
  end

  // ==========================================================================
  // power down control; writes ignored while held in reset
  always_ff @(posedge mclk) begin
    if (srst || cfg_ff.soft_reset) begin
      cfg_ff.pd_i_dac   <= dcr_pkg::PD_I_DAC_RST;
      cfg_ff.pd_q_dac   <= dcr_pkg::PD_Q_DAC_RST;
      cfg_ff.pd_rx      <= dcr_pkg::PD_RX_RST;
      cfg_ff.pd_aux_adc <= dcr_pkg::PD_AUX_ADC_RST;
    end else if (wr_stb_ff && addr_ff == dcr_pkg::ADDR_POWER_DOWN_CTRL) begin
      cfg_ff.pd_i_dac   <= wr_data_ff[dcr_pkg::PD_I_DAC_BIT];
      cfg_ff.pd_q_dac   <= wr_data_ff[dcr_pkg::PD_Q_DAC_BIT];
      cfg_ff.pd_rx      <= wr_data_ff[dcr_pkg::PD_RX_BIT];
      cfg_ff.pd_aux_adc <= wr_data_ff[dcr_pkg::PD_AUX_ADC_BIT];
    end
  end

  // ==========================================================================
  // input data format
  always_ff @(posedge mclk) begin
    if (srst || cfg_ff.soft_reset) begin
      cfg_ff.fmt_binary <= dcr_pkg::FMT_BINARY_RST;
      cfg_ff.q_first    <= dcr_pkg::FMT_Q_FIRST_RST;
    end else if (wr_stb_ff && addr_ff == dcr_pkg::ADDR_INPUT_DATA_FMT) begin
      cfg_ff.fmt_binary <= wr_data_ff[dcr_pkg::FMT_BINARY_BIT];
      cfg_ff.q_first    <= wr_data_ff[dcr_pkg::FMT_Q_FIRST_BIT];
    end
  end

  // ==========================================================================
  // count outputs registered once more for the data path
  always_ff @(posedge mclk) begin
    if (srst) begin
      i_err_count_ff <= '0;
      q_err_count_ff <= '0;
    end else begin
      i_err_count_ff <= i_cnt;
      q_err_count_ff <= q_cnt;
    end
  end

endmodule : dcr_bank

// ---- tb/dcr_bank_sva.sv ----
// concurrent checks on the ports of the configuration register bank
`timescale 1ns/1ps
module dcr_bank_sva #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic             mclk,
  input wire logic             srst,
  // serial pins
  input wire logic             csb_n,
  input wire logic             sclk,
  input wire logic             sdio_i,
  input wire logic             sdio_o_ff,
  input wire logic             sdio_oe_ff,
  input wire logic             sdo_ff,
  // events and outputs
  input wire logic             i_sample_err,
  input wire logic             q_sample_err,
  input dcr_pkg::dcr_cfg_t     cfg_ff,
  input wire logic             dev_reset_ff,
  input wire logic [CNT_W-1:0] i_err_count_ff,
  input wire logic [CNT_W-1:0] q_err_count_ff
);
  // ==========================================================================
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  a_reset_dflt : assert property (disable iff (1'b0)
    srst |=> cfg_ff == 9'h004 && !dev_reset_ff && i_err_count_ff == '0)
    else $error("reset values wrong");
  a_soft_follow : assert property (
    !$past(srst) |-> dev_reset_ff == $past(cfg_ff.soft_reset))
    else $error("device reset does not follow control bit");
  a_soft_cfg_dflt : assert property (
    $past(dev_reset_ff) && dev_reset_ff |-> cfg_ff[5:0] == 6'h04)
    else $error("config not at defaults in reset");
  a_cnt_held_zero : assert property (
    dev_reset_ff [*3] |-> i_err_count_ff == '0 && q_err_count_ff == '0)
    else $error("counts not held at zero");
  a_i_err_step : assert property (
    i_sample_err && !dev_reset_ff && !cfg_ff.soft_reset && i_err_count_ff < 16'hfffe
    |-> ##2 i_err_count_ff == $past(i_err_count_ff) + 16'h0001)
    else $error("i count did not step");
  a_q_err_step : assert property (
    q_sample_err && !dev_reset_ff && !cfg_ff.soft_reset && q_err_count_ff < 16'hfffe
    |-> ##2 q_err_count_ff == $past(q_err_count_ff) + 16'h0001)
    else $error("q count did not step");
  a_oe_needs_bidir : assert property (
    sdio_oe_ff |-> cfg_ff.sdio_bidir && sdio_o_ff == sdo_ff)
    else $error("data pin driven while input only");
  a_idle_quiet : assert property (
    csb_n [*6] |-> !sdio_oe_ff && !sdo_ff)
    else $error("serial outputs active outside frame");
  a_cfg_idle_hold : assert property (
    csb_n [*8] |-> $stable(cfg_ff))
    else $error("config changed with no frame");

  // ==========================================================================
  // covers
  c_soft_reset : cover property (dev_reset_ff);
  c_bidir_read : cover property (sdio_oe_ff);
  c_pd_write   : cover property ($rose(cfg_ff.pd_i_dac));
endmodule : dcr_bank_sva

bind dcr_bank dcr_bank_sva #(.CNT_W(CNT_W)) chk_u (
  .mclk(mclk), .srst(srst), .csb_n(csb_n), .sclk(sclk), .sdio_i(sdio_i),
  .sdio_o_ff(sdio_o_ff), .sdio_oe_ff(sdio_oe_ff), .sdo_ff(sdo_ff),
  .i_sample_err(i_sample_err), .q_sample_err(q_sample_err), .cfg_ff(cfg_ff),
  .dev_reset_ff(dev_reset_ff), .i_err_count_ff(i_err_count_ff),
  .q_err_count_ff(q_err_count_ff));

// ---- tb/dcr_host_model.sv ----
// host controller model driving the four-wire serial port
`timescale 1ns/1ps
module dcr_host_model #(
  parameter int HALF = 6
) (
  // clock
  input wire logic mclk,
  // serial pins
  output logic     csb_n,
  output logic     sclk,
  output logic     sdio_h,
  input wire logic sdio_line,
  input wire logic sdo
);
  // ==========================================================================
  // frame driver
  initial begin
    csb_n  = 1'b1;
    sclk   = 1'b0;
    sdio_h = 1'b0;
  end

  // sclk stands low between frames; a released data line toggles, never holds
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d,
                      input logic lsb, input logic bidir, output logic [7:0] q);
    logic [15:0] f;
    int          j;
    f = {rd, a, d};
    q = 8'h00;
    @(posedge mclk) #1 csb_n = 1'b0;
    for (int i = 0; i < 16; i++) begin
      j = lsb ? i % 8 : 7 - i % 8;
      sdio_h = (rd && i > 7) ? ~sdio_h : f[(i > 7) ? j : j + 8];
      repeat (HALF) @(posedge mclk);
      #1 sclk = 1'b1;
      if (rd && i > 7) q[j] = bidir ? sdio_line : sdo;
      repeat (HALF) @(posedge mclk);
      #1 sclk = 1'b0;
    end
    repeat (HALF) @(posedge mclk);
    #1 csb_n = 1'b1;
    sdio_h = ~sdio_h;
    repeat (HALF) @(posedge mclk);
  endtask : xfer
endmodule : dcr_host_model

// ---- tb/tb_dac_config_register_bank.sv ----
// self-checking bench of the dac configuration register bank
`timescale 1ns/1ps
module tb_dac_config_register_bank;
  // ==========================================================================
  // signals and model state
  localparam logic [3:0] REV   = 4'h9; // arbitrary revision value
  localparam int         LIMIT = 40000;
  logic              mclk = 1'b0;
  logic              srst = 1'b1;
  logic              i_err = 1'b0;
  logic              q_err = 1'b0;
  logic              csb_n, sclk, sdio_h, sdio_o_ff, sdio_oe_ff, sdo_ff, dev_reset_ff;
  dcr_pkg::dcr_cfg_t cfg_ff;
  logic [15:0]       i_cnt, q_cnt;
  logic [15:0]       ci = 16'h0000;
  logic [15:0]       cq = 16'h0000;
  logic [7:0]        spc_m = 8'h00;
  logic [7:0]        pd_m = 8'h10;
  logic [7:0]        fmt_m = 8'h00;
  logic [7:0]        q;
  logic [6:0]        addrs [10] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h50,
                                    7'h70, 7'h71, 7'h72, 7'h73, 7'h7f};
  int                n_fail = 0;
  int                n_tests = 0;
  int                cyc = 0;
  wire logic         sdio_line = sdio_oe_ff ? sdio_o_ff : sdio_h;

  dcr_bank #(.CNT_W(16), .REVISION(REV)) dut_u (
    .mclk(mclk), .srst(srst), .csb_n(csb_n), .sclk(sclk), .sdio_i(sdio_line),
    .sdio_o_ff(sdio_o_ff), .sdio_oe_ff(sdio_oe_ff), .sdo_ff(sdo_ff),
    .i_sample_err(i_err), .q_sample_err(q_err), .cfg_ff(cfg_ff),
    .dev_reset_ff(dev_reset_ff), .i_err_count_ff(i_cnt), .q_err_count_ff(q_cnt));

  dcr_host_model host_u (
    .mclk(mclk), .csb_n(csb_n), .sclk(sclk), .sdio_h(sdio_h),
    .sdio_line(sdio_line), .sdo(sdo_ff));

  always #2 mclk = ~mclk;

  always @(posedge mclk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_fail++;
      complete_run();
    end
  end

  // ==========================================================================
  // compare, expectation and access tasks
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8

  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk16

  function automatic logic [7:0] exp_rd(input logic [6:0] a);
    case (a)
      7'h00:   return spc_m;
      7'h01:   return pd_m;
      7'h03:   return fmt_m;
      7'h70:   return ci[7:0];
      7'h71:   return ci[15:8];
      7'h72:   return cq[7:0];
      7'h73:   return cq[15:8];
      7'h7f:   return {2'b00, REV, 2'b00};
      default: return 8'h00;
    endcase
  endfunction : exp_rd

  task automatic chk_cfg();
    chk16("cfg", {7'h00, spc_m[7:5], pd_m[7:4], fmt_m[7:6]}, {7'h00, cfg_ff});
  endtask : chk_cfg

  // bit order change only applies from the frame after the write
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host_u.xfer(1'b0, a, d, spc_m[6], spc_m[7], q);
    if (a == 7'h00) spc_m = d & 8'he0;
    if (a == 7'h01 && !spc_m[5]) pd_m = d & 8'hf0;
    if (a == 7'h03 && !spc_m[5]) fmt_m = d & 8'hc0;
    if (spc_m[5]) begin
      pd_m  = 8'h10;
      fmt_m = 8'h00;
      ci    = 16'h0000;
      cq    = 16'h0000;
    end
  endtask : wr

  task automatic rd(input logic [6:0] a);
    host_u.xfer(1'b1, a, 8'h00, spc_m[6], spc_m[7], q);
    chk8($sformatf("reg %h", a), exp_rd(a), q);
  endtask : rd

  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge mclk) #1 {i_err, q_err} = 2'($urandom);
      if (!spc_m[5] && i_err && ci != 16'hffff) ci++;
      if (!spc_m[5] && q_err && cq != 16'hffff) cq++;
    end
    @(posedge mclk) #1 {i_err, q_err} = 2'b00;
    repeat (4) @(posedge mclk);
    chk16("i count", ci, i_cnt);
    chk16("q count", cq, q_cnt);
  endtask : pulse

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run

  // ==========================================================================
  // main sequence
  initial begin
    void'($urandom(61));
    repeat (20) @(posedge mclk);
    #1 srst = 1'b0;
    repeat (5) @(posedge mclk);
    chk_cfg();
    foreach (addrs[k]) rd(addrs[k]);
    for (int k = 0; k < 6; k++) begin
      wr(7'h01, 8'($urandom));
      wr(7'h03, 8'($urandom));
      chk_cfg();
      rd(7'h01);
      rd(7'h03);
    end
    wr(7'h71, 8'hff);
    pulse(80);
    foreach (addrs[k]) rd(addrs[k]);
    wr(7'h00, 8'h80);
    rd(7'h7f);
    wr(7'h00, 8'hc0);
    wr(7'h03, 8'h80);
    rd(7'h03);
    chk_cfg();
    wr(7'h00, 8'h00);
    rd(7'h00);
    wr(7'h00, 8'h40);
    rd(7'h7f);
    wr(7'h01, 8'he0);
    wr(7'h00, 8'h20);
    chk_cfg();
    chk16("dev reset", 16'h0001, {15'h0000, dev_reset_ff});
    wr(7'h01, 8'hc0);
    pulse(30);
    foreach (addrs[k]) rd(addrs[k]);
    wr(7'h00, 8'h00);
    chk16("dev reset", 16'h0000, {15'h0000, dev_reset_ff});
    pulse(30);
    complete_run();
  end
endmodule : tb_dac_config_register_bank
